// ### rsfl_status_flags.sv
// Event status and interrupt enable registers of the real-time clock
//
// Summary of operation
// - Bit 7 reads 0 on main supply, 1 on backup supply.
// - Bit 6 is one while oscillator stopped, zero when running or disabled.
// - The oscillator-stop flag never drives the interrupt output.
// - Bit 5 latches power fail; interrupts when its enable is one.
// - Power-fail flag stays latched until the host reads status.
// - Bit 3 latches one-shot temperature done; interrupts when enabled.
// - Bit 2 latches timer reaching zero; interrupts when enabled.
// - Bit 1 latches alarm-2 match; interrupts when enabled.
// - Enable bit 6 set forces the oscillator-stop flag to zero.
`timescale 1ns/1ns
module rsfl_status_flags (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register access from the serial bus engine
    input wire rsfl_pkg::rsfl_bus_type i_bus,
    output logic [7:0] o_rdata,
    // Events from the timekeeping engines, asynchronous levels
    input wire rsfl_pkg::rsfl_event_type i_evt,
    // Active-low interrupt pin
    output logic o_int_n
);
    import rsfl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronise event inputs

    rsfl_event_type evt_s1_r;
    rsfl_event_type evt_s2_r;
    rsfl_event_type evt_d_r;

    // Synchroniser value in reset: oscillator seen as stopped, all else idle
    localparam rsfl_event_type EVT_RESET = '{osc_stopped: RSFL_OSC_RESET, default: 1'b0};

    // Two-stage synchroniser, then a delay for edge detection
    // The oscillator bit resets to stopped, as the flag does, so the flag
    // does not drop for two cycles while a stopped level walks through
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evt_s1_r <= EVT_RESET;
            evt_s2_r <= EVT_RESET;
            evt_d_r <= '0;
        end else begin
            evt_s1_r <= i_evt;
            evt_s2_r <= evt_s1_r;
            evt_d_r <= evt_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic [7:0] irq_en_r;
    logic [7:0] irq_en_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic osc_flag_r;
    logic osc_flag_nxt;
    logic [7:0] status;
    logic [RSFL_NUM_LATCHED-1:0] set_vec;
    logic [RSFL_NUM_LATCHED-1:0] flag_vec;
    logic [RSFL_NUM_LATCHED-1:0] en_vec;
    logic status_rd;
    logic en_wr;
    logic en_rd;
    logic osc_disable;

    // Address decode of the two registers
    assign status_rd = i_bus.rd & (i_bus.addr == RSFL_STATUS_ADDR);
    assign en_rd = i_bus.rd & (i_bus.addr == RSFL_IRQ_EN_ADDR);
    assign en_wr = i_bus.wr & (i_bus.addr == RSFL_IRQ_EN_ADDR);
    assign irq_en_nxt = en_wr ? (i_bus.wdata & RSFL_IRQ_EN_MASK) : irq_en_r;
    assign osc_disable = irq_en_r[RSFL_OSC_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Latched flags

    // Still-high level sources also set again after a read
    assign set_vec = {evt_s2_r.power_fail,
                      evt_s2_r.temp_done & ~evt_d_r.temp_done,
                      evt_s2_r.timer_zero & ~evt_d_r.timer_zero,
                      evt_s2_r.alarm2_match & ~evt_d_r.alarm2_match,
                      evt_s2_r.alarm1_match & ~evt_d_r.alarm1_match};
    assign en_vec = {irq_en_r[RSFL_POWER_FAIL_FLAG_BIT], irq_en_r[RSFL_TEMP_BIT], irq_en_r[RSFL_TIMER_BIT],
                     irq_en_r[RSFL_ALARM2_BIT], irq_en_r[RSFL_ALARM1_BIT]};

    // One latched cell per event flag
    genvar g;
    generate
        for (g = 0; g < RSFL_NUM_LATCHED; g++) begin : g_flag
            rsfl_flag_cell u_cell (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_set(set_vec[g]),
                .i_clear(status_rd),
                .o_flag(flag_vec[g])
            );
        end
    endgenerate

    // Oscillator flag follows oscillator state unless disabled
    assign osc_flag_nxt = evt_s2_r.osc_stopped & ~osc_disable;

    // Status image
    assign status = {evt_s2_r.on_backup, osc_flag_r, flag_vec[4], 1'b0, flag_vec[3:0]};
    assign rdata_nxt = status_rd ? status : (en_rd ? irq_en_r : rdata_r);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and outputs

    // Enable register, oscillator flag and read data
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_en_r <= RSFL_IRQ_EN_RESET;
            osc_flag_r <= RSFL_OSC_RESET;
            rdata_r <= 8'h00;
        end else begin
            irq_en_r <= irq_en_nxt;
            osc_flag_r <= osc_flag_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Oscillator flag is left out of the interrupt on purpose
    assign o_int_n = ~|(flag_vec & en_vec);
    assign o_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Nothing latched keeps the pin high, whatever the oscillator flag says
    osc_no_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (osc_flag_r && ~|flag_vec) |-> o_int_n)
        else $error("interrupt asserted by oscillator flag");
    osc_disable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        osc_disable |=> !osc_flag_r)
        else $error("oscillator flag set while disabled");
    osc_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (evt_s2_r.osc_stopped && !osc_disable) |=> osc_flag_r)
        else $error("oscillator flag missed a stop");
    supply_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_SUPPLY_BIT] == $past(evt_s2_r.on_backup))
        else $error("supply bit wrong");
    power_fail_flag_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (evt_s2_r.power_fail && irq_en_r[RSFL_POWER_FAIL_FLAG_BIT] && !en_wr) |=> !o_int_n)
        else $error("power fail interrupt missing");
    power_fail_flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (flag_vec[4] && !status_rd) |=> flag_vec[4])
        else $error("power fail flag lost without read");
    read_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (status_rd && set_vec == '0) |=> flag_vec == '0)
        else $error("status read did not clear flags");
    timer_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        set_vec[2] |=> flag_vec[2])
        else $error("timer flag not set");
    alarm2_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        set_vec[1] |=> flag_vec[1])
        else $error("alarm2 flag not set");
    alarm1_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        set_vec[0] |=> flag_vec[0])
        else $error("alarm1 flag not set");
    temp_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        set_vec[3] |=> flag_vec[3])
        else $error("temperature flag not set");
    power_fail_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        set_vec[4] |=> flag_vec[4])
        else $error("power fail flag not set");

    // Each flag lands on its own status bit when read
    power_fail_flag_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_POWER_FAIL_FLAG_BIT] == $past(flag_vec[4]))
        else $error("power fail flag read on wrong bit");
    temp_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_TEMP_BIT] == $past(flag_vec[3]))
        else $error("temperature flag read on wrong bit");
    timer_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_TIMER_BIT] == $past(flag_vec[2]))
        else $error("timer flag read on wrong bit");
    alarm2_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_ALARM2_BIT] == $past(flag_vec[1]))
        else $error("alarm2 flag read on wrong bit");
    alarm1_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_ALARM1_BIT] == $past(flag_vec[0]))
        else $error("alarm1 flag read on wrong bit");
    osc_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> o_rdata[RSFL_OSC_BIT] == $past(osc_flag_r))
        else $error("oscillator flag read on wrong bit");
    spare_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_rd |=> !o_rdata[4])
        else $error("unused status bit reads one");

    // Enable register keeps only the documented bits and reads them back
    en_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        en_wr |=> irq_en_r == ($past(i_bus.wdata) & RSFL_IRQ_EN_MASK))
        else $error("enable write not kept");
    en_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        en_rd |=> o_rdata == $past(irq_en_r))
        else $error("enable read data wrong");
    en_spare_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !irq_en_r[7] && !irq_en_r[4])
        else $error("unused enable bit set");
    rdata_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(status_rd || en_rd) |=> $stable(o_rdata))
        else $error("read data changed without a read");

    // Interrupt pin goes low for each enabled latched temperature, timer and alarm flag
    temp_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (flag_vec[3] && en_vec[3]) |-> !o_int_n)
        else $error("temperature interrupt missing");
    timer_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (flag_vec[2] && en_vec[2]) |-> !o_int_n)
        else $error("timer interrupt missing");
    alarm2_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (flag_vec[1] && en_vec[1]) |-> !o_int_n)
        else $error("alarm2 interrupt missing");
    alarm1_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (flag_vec[0] && en_vec[0]) |-> !o_int_n)
        else $error("alarm1 interrupt missing");

endmodule : rsfl_status_flags

// ### rsfl_pkg.sv
// Package for the real-time clock event status flag logic
package rsfl_pkg;

    // Register offsets on the serial register bus
    localparam logic [7:0] RSFL_STATUS_ADDR = 8'h00;
    localparam logic [7:0] RSFL_IRQ_EN_ADDR = 8'h01;

    // Bit positions, shared by status and enable registers
    localparam int RSFL_SUPPLY_BIT = 7;
    localparam int RSFL_OSC_BIT = 6;
    localparam int RSFL_POWER_FAIL_FLAG_BIT = 5;
    localparam int RSFL_TEMP_BIT = 3;
    localparam int RSFL_TIMER_BIT = 2;
    localparam int RSFL_ALARM2_BIT = 1;
    localparam int RSFL_ALARM1_BIT = 0;
    localparam int RSFL_NUM_LATCHED = 5;

    // Values after reset, and the mask of writable enable bits
    localparam logic [7:0] RSFL_IRQ_EN_RESET = 8'h00;
    localparam logic RSFL_OSC_RESET = 1'b1;
    localparam logic [7:0] RSFL_IRQ_EN_MASK = 8'h6f;

    // Event pulses and levels coming from the timekeeping engines
    typedef struct packed {
        logic on_backup;
        logic osc_stopped;
        logic power_fail;
        logic temp_done;
        logic timer_zero;
        logic alarm2_match;
        logic alarm1_match;
    } rsfl_event_type;

    // Register access strobes from the serial bus engine
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } rsfl_bus_type;

endpackage : rsfl_pkg

// ### rsfl_flag_cell.sv
// One latched event flag cleared by a status read
`timescale 1ns/1ns
module rsfl_flag_cell (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Event and clear
    input wire logic i_set,
    input wire logic i_clear,
    // Flag
    output logic o_flag
);

    logic flag_r;
    logic flag_nxt;

    // Set wins over a clear in the same cycle
    assign flag_nxt = i_set | (flag_r & ~i_clear);
    assign o_flag = flag_r;

    // Flag storage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : rsfl_flag_cell

// ### rsfl_host_model.sv
// Host model that issues register strobes toward the status flag block
`timescale 1ns/1ns
module rsfl_host_model (
    // Clock
    input wire logic i_clk,
    // Register access toward the block
    output rsfl_pkg::rsfl_bus_type o_bus
);
    import rsfl_pkg::*;

    // One-cycle strobe, launched and dropped on falling edges
    task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data);
        @(negedge i_clk);
        o_bus = '{addr: addr, rd: !wr, wr: wr, wdata: data};
        @(negedge i_clk);
        o_bus = '{addr: ~addr, rd: 1'b0, wr: 1'b0, wdata: ~data}; // Released lines do not keep old value
    endtask : access

    // Idle bus from time zero
    initial begin
        o_bus = '0;
    end
endmodule : rsfl_host_model

// ### tb_rsfl_status_flags.sv
// Self-checking bench for the event status flag logic
`timescale 1ns/1ns
module tb_rsfl_status_flags;
    import rsfl_pkg::*;
    logic i_clk;
    logic i_rst_n;
    rsfl_bus_type bus;
    rsfl_event_type evt;
    logic [7:0] o_rdata;
    logic o_int_n;
    logic [7:0] en;
    int n_mismatch;
    int check_count;
    int seed;
    int b;
    int sbit [5] = '{RSFL_POWER_FAIL_FLAG_BIT, RSFL_TEMP_BIT, RSFL_TIMER_BIT, RSFL_ALARM2_BIT, RSFL_ALARM1_BIT};
    int ebit [5] = '{4, 3, 2, 1, 0};

    ////////////////////////////////////////////////////////////////////////////////
    rsfl_host_model host (.i_clk(i_clk), .o_bus(bus));
    rsfl_status_flags dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(o_rdata),
        .i_evt(evt), .o_int_n(o_int_n));

    // Clock generator
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Register read, data valid once the task returns
    task automatic rd(input logic [7:0] addr);
        host.access(addr, 1'b0, 8'h00);
    endtask : rd

    // Status expected for the given latched flags and present levels
    function automatic logic [7:0] exp_status(input logic [7:0] flags);
        return flags | {evt.on_backup, evt.osc_stopped & !en[RSFL_OSC_BIT], 6'h00};
    endfunction : exp_status

    // Counts and verdict, then end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // Hang guard
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_mismatch = 0;
        check_count = 0;
        seed = 32'hdf82;
        en = 8'h00;
        evt = '0;
        evt.osc_stopped = 1'b1;
        i_rst_n = 1'b0;
        repeat (6) @(negedge i_clk);
        i_rst_n = 1'b1;
        rd(RSFL_STATUS_ADDR);
        check("status after reset", o_rdata, 8'h40);
        en = 8'hbf;
        host.access(RSFL_IRQ_EN_ADDR, 1'b1, en);
        host.access(RSFL_STATUS_ADDR, 1'b1, 8'hff);
        rd(RSFL_STATUS_ADDR);
        check("status osc", o_rdata, 8'h40);
        check("int from osc", o_int_n, 1'b1);
        rd(RSFL_IRQ_EN_ADDR);
        check("enable read", o_rdata, 8'h2f);
        // Random enables, each latched flag raised by a one-cycle event
        for (int r = 0; r < 20; r++) begin
            b = r % 5;
            en = 8'($random(seed)) & RSFL_IRQ_EN_MASK;
            host.access(RSFL_IRQ_EN_ADDR, 1'b1, en);
            evt.on_backup = 1'($random(seed));
            evt[ebit[b]] = 1'b1;
            @(negedge i_clk);
            evt[ebit[b]] = 1'b0;
            repeat (4) @(negedge i_clk);
            check("int pin", o_int_n, !en[sbit[b]]);
            rd(RSFL_STATUS_ADDR);
            check("status set", o_rdata, exp_status(8'h01 << sbit[b]));
            rd(RSFL_STATUS_ADDR);
            check("status cleared", o_rdata, exp_status(8'h00));
            check("int cleared", o_int_n, 1'b1);
        end
        rd(8'h07);
        check("rdata held", o_rdata, exp_status(8'h00));
        // Power fail still present across reads
        evt.power_fail = 1'b1;
        repeat (4) @(negedge i_clk);
        rd(RSFL_STATUS_ADDR);
        rd(RSFL_STATUS_ADDR);
        check("power_fail_flag reappears", o_rdata, exp_status(8'h20));
        // Reset in mid-run while power fail stays present
        evt.on_backup = 1'b0;
        en = 8'h00;
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        check("int in reset", o_int_n, 1'b1);
        i_rst_n = 1'b1;
        rd(RSFL_STATUS_ADDR);
        check("status after second reset", o_rdata, 8'h40);
        repeat (4) @(negedge i_clk);
        rd(RSFL_STATUS_ADDR);
        check("power_fail_flag after second reset", o_rdata, exp_status(8'h20));
        give_verdict();
    end
endmodule : tb_rsfl_status_flags
